// file: rtl/assc_ctrl.sv
// Purpose: Sensor-support control of a delta-sigma converter.
// Assumes: Register writes and reads arrive already decoded from the serial port.
// Notes: All outputs are registered; analog switches are driven as enables.
//
// Summary of operation
// RL1 - Start conversion on trigger edge or seventh clock
// RL2 - Line rejection only at 60 SPS or slower
// RL3 - Magnitude field at 06h sets both sources
// RL4 - Each source routed by own field at 07h
// RL5 - Both sources may share one pin
// RL6 - Host enables reference before using sources
// RL7 - Bias pin select bits at 08h
// RL8 - Host waits for bias settling before converting
// RL9 - Selector at 09h, code 010 temperature
// RL10 - Temperature: inputs disconnected, normal gain kept
// RL11 - Host keeps gain at most 4 for temperature
// RL12 - Codes 011 and 100 select supply readings
// RL13 - Supply monitor disconnects inputs, forces unity gain
// RL14 - Supply monitor honours amplifier enable field
// RL15 - Codes 101,110,111 enable burnout currents
// RL16 - Burnout sources positive, sinks negative input
// RL17 - Host uses burnout only for fault checks
// RL18 - Status byte at 01h holds three flags
// RL19 - Power-on flag bit 7 set at reset
// RL20 - Power-on flag cleared by writing zero
// RL21 - Bit 6 shows startup complete
// RL22 - Bit 0 shows reference below threshold
// RL23 - Reference fault latched, updated at ready fall
// RL24 - Code 000 leaves monitors off
`timescale 1ns/1ps
module assc_ctrl #(
    parameter int STARTUP = assc_pkg::STARTUP_CYCLES
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Register port.
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Conversion triggers.
    input wire logic start_pin_i,
    input wire logic start_cmd_i,
    input wire logic sclk_fall_i,
    input wire logic conv_done_i,
    input wire logic ref_low_i,
    // Converter controls.
    output logic conv_start_o,
    output logic line_rej_o,
    output logic [3:0] current_magnitude_field_o,
    output logic [3:0] first_current_route_o,
    output logic [3:0] second_current_route_o,
    output logic [6:0] bias_pin_select_o,
    output logic inputs_connect_o,
    output logic temp_sel_o,
    output logic analog_supply_sel_o,
    output logic digital_supply_sel_o,
    output logic [2:0] eff_gain_o,
    output logic [1:0] amp_enable_o,
    output logic [1:0] burnout_level_o,
    output logic burnout_en_o,
    output logic data_ready_n_o
);
    logic [7:0] gain_r;
    logic [7:0] rate_r;
    logic [7:0] mag_r;
    logic [7:0] route_r;
    logic [7:0] bias_r;
    logic [7:0] sys_r;
    logic por_r;
    logic rdy_r;
    logic reflow_r;
    logic ref_fault_r;
    logic start_d_r;
    logic [2:0] sclk_cnt_r;
    logic [$clog2(STARTUP+1)-1:0] boot_r;
    logic [2:0] mon;
    logic wr_stat;

    assign mon = sys_r[7:5];
    assign wr_stat = reg_wr_i && reg_addr_i == assc_pkg::ADDR_STATUS;

    // Configuration registers written by the host.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            gain_r <= assc_pkg::RST_GAIN;
            rate_r <= assc_pkg::RST_RATE;
            mag_r <= assc_pkg::RST_EXC_MAG;
            route_r <= assc_pkg::RST_EXC_ROUTE;
            bias_r <= assc_pkg::RST_BIAS_SEL;
            sys_r <= assc_pkg::RST_SYS_CTRL;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                assc_pkg::ADDR_GAIN: gain_r <= reg_wdata_i;
                assc_pkg::ADDR_RATE: rate_r <= reg_wdata_i;
                assc_pkg::ADDR_EXC_MAG: mag_r <= reg_wdata_i; // [RL3]
                assc_pkg::ADDR_EXC_ROUTE: route_r <= reg_wdata_i; // [RL4]
                assc_pkg::ADDR_BIAS_SEL: bias_r <= reg_wdata_i; // [RL7]
                assc_pkg::ADDR_SYS_CTRL: sys_r <= reg_wdata_i; // [RL9]
                default: ;
            endcase
        end
    end

    // Power-on flag: set by reset, cleared only by writing zero to it.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            por_r <= 1'b1; // [RL19]
        else if (wr_stat && !reg_wdata_i[assc_pkg::POS_POR])
            por_r <= 1'b0; // [RL20]
    end

    // Startup counter raises the ready flag once reset work is done.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            boot_r <= '0;
            rdy_r <= 1'b0;
        end
        else if (boot_r != STARTUP[$bits(boot_r)-1:0])
            boot_r <= boot_r + 1'b1;
        else
            rdy_r <= 1'b1; // [RL21]
    end

    // Reference fault is latched during the cycle, published as ready falls.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            ref_fault_r <= 1'b0;
            reflow_r <= 1'b0;
            data_ready_n_o <= 1'b1;
        end
        else
        begin
            if (conv_done_i)
            begin
                reflow_r <= ref_fault_r | ref_low_i; // [RL22] [RL23]
                ref_fault_r <= 1'b0;
                data_ready_n_o <= 1'b0;
            end
            else
            begin
                ref_fault_r <= ref_fault_r | ref_low_i; // [RL23]
                if (conv_start_o)
                    data_ready_n_o <= 1'b1;
            end
        end
    end

    // Start detection: trigger pin rising edge or seventh clock of command.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            start_d_r <= 1'b0;
            sclk_cnt_r <= '0;
            conv_start_o <= 1'b0;
        end
        else
        begin
            start_d_r <= start_pin_i;
            if (!start_cmd_i)
                sclk_cnt_r <= '0;
            else if (sclk_fall_i && sclk_cnt_r != assc_pkg::START_SCLK_EDGE)
                sclk_cnt_r <= sclk_cnt_r + 3'd1;
            conv_start_o <= (start_pin_i && !start_d_r) // [RL1]
                || (start_cmd_i && sclk_fall_i
                && sclk_cnt_r == assc_pkg::START_SCLK_EDGE - 3'd1);
        end
    end

    // Decoded analog controls follow the register contents.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            line_rej_o <= 1'b0;
            current_magnitude_field_o <= '0;
            first_current_route_o <= '1;
            second_current_route_o <= '1;
            bias_pin_select_o <= '0;
            inputs_connect_o <= 1'b1;
            temp_sel_o <= 1'b0;
            analog_supply_sel_o <= 1'b0;
            digital_supply_sel_o <= 1'b0;
            eff_gain_o <= '0;
            amp_enable_o <= '0;
            burnout_level_o <= '0;
            burnout_en_o <= 1'b0;
        end
        else
        begin
            line_rej_o <= rate_r[3:0] <= assc_pkg::RATE_LINE_REJ_MAX; // [RL2]
            current_magnitude_field_o <= mag_r[3:0]; // [RL3]
            // Both routes are independent; equal codes stack on one pin.
            first_current_route_o <= route_r[3:0]; // [RL4] [RL5]
            second_current_route_o <= route_r[7:4]; // [RL4] [RL5]
            bias_pin_select_o <= bias_r[6:0]; // [RL7]
            temp_sel_o <= mon == assc_pkg::MON_TEMP; // [RL9]
            analog_supply_sel_o <= mon == assc_pkg::MON_AVDD; // [RL12]
            digital_supply_sel_o <= mon == assc_pkg::MON_DVDD; // [RL12]
            inputs_connect_o <= !(mon == assc_pkg::MON_TEMP || mon == assc_pkg::MON_AVDD
                || mon == assc_pkg::MON_DVDD); // [RL10] [RL13] [RL24]
            if (mon == assc_pkg::MON_AVDD || mon == assc_pkg::MON_DVDD)
                eff_gain_o <= 3'd0; // [RL13]
            else
                eff_gain_o <= gain_r[2:0]; // [RL10]
            amp_enable_o <= gain_r[6:5]; // [RL14]
            burnout_en_o <= mon >= assc_pkg::MON_BO_0P2; // [RL15] [RL16]
            burnout_level_o <= mon >= assc_pkg::MON_BO_0P2 ? mon[1:0] : 2'd0; // [RL15]
        end
    end

    // Read-back multiplexer.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            reg_rdata_o <= '0;
        else
        begin
            case (reg_addr_i)
                assc_pkg::ADDR_STATUS: reg_rdata_o <= {por_r, rdy_r, 5'd0, reflow_r}; // [RL18]
                assc_pkg::ADDR_GAIN: reg_rdata_o <= gain_r;
                assc_pkg::ADDR_RATE: reg_rdata_o <= rate_r;
                assc_pkg::ADDR_EXC_MAG: reg_rdata_o <= mag_r;
                assc_pkg::ADDR_EXC_ROUTE: reg_rdata_o <= route_r;
                assc_pkg::ADDR_BIAS_SEL: reg_rdata_o <= bias_r;
                assc_pkg::ADDR_SYS_CTRL: reg_rdata_o <= sys_r;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Checks.
    a_por_set: assert property (@(posedge ref_clk_i) $fell(rst_i) |-> por_r) // [RL19]
        else $error("power-on flag not set after reset");
    a_por_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $fell(por_r) |-> $past(wr_stat) && !$past(reg_wdata_i[7])) // [RL20]
        else $error("power-on flag cleared without write");
    a_supply_gain: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mon == assc_pkg::MON_AVDD) |=> eff_gain_o == 3'd0 && !inputs_connect_o) // [RL13]
        else $error("supply monitor gain not forced");
    a_temp_conn: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mon == assc_pkg::MON_TEMP) |=> !inputs_connect_o && eff_gain_o == $past(gain_r[2:0])) // [RL10]
        else $error("temperature path wrong");
    a_off_conn: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mon == assc_pkg::MON_OFF) |=> inputs_connect_o && !burnout_en_o) // [RL24]
        else $error("monitor off not clean");
    a_start_pin: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(start_pin_i) |=> conv_start_o) // [RL1]
        else $error("start edge missed");
    a_line_rej: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rate_r[3:0] > 4'h6) |=> !line_rej_o) // [RL2]
        else $error("line rejection above limit");
    a_burnout_on: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (mon == assc_pkg::MON_BO_10) |=> burnout_en_o && burnout_level_o == 2'd3) // [RL15]
        else $error("burnout level wrong");
    a_rdy_start: assert property (@(posedge ref_clk_i) $fell(rst_i) |-> !rdy_r) // [RL21]
        else $error("ready during reset");
    a_route_pair: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        1'b1 |=> first_current_route_o == $past(route_r[3:0])) // [RL4]
        else $error("route mismatch");

    // A command start needs its seventh serial fall, and no start appears without a cause.
    a_cmd_start: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL1]
        (start_cmd_i && sclk_fall_i && sclk_cnt_r == assc_pkg::START_SCLK_EDGE - 3'd1)
        |=> conv_start_o)
        else $error("command start missed");
    a_start_cause: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL1]
        conv_start_o |-> $past(start_pin_i && !start_d_r)
        || $past(start_cmd_i && sclk_fall_i))
        else $error("start without a cause");
    a_line_rej_on: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL2]
        (rate_r[3:0] <= assc_pkg::RATE_LINE_REJ_MAX) |=> line_rej_o)
        else $error("line rejection missing at low rate");

    // Excitation and bias fields reach their outputs one cycle after the register.
    a_mag_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL3]
        1'b1 |=> current_magnitude_field_o == $past(mag_r[3:0]))
        else $error("magnitude mismatch");
    a_route_second: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL4]
        1'b1 |=> second_current_route_o == $past(route_r[7:4]))
        else $error("second route mismatch");
    a_route_shared: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL5]
        (route_r[3:0] == route_r[7:4]) |=> first_current_route_o == second_current_route_o)
        else $error("shared route split");
    a_bias_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL7]
        1'b1 |=> bias_pin_select_o == $past(bias_r[6:0]))
        else $error("bias select mismatch");

    // Selector codes drive their own monitor paths; exclusivity is checked for the temperature code, and against temperature for the AVDD code.
    a_temp_sel: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL9]
        (mon == assc_pkg::MON_TEMP) |=> temp_sel_o && !analog_supply_sel_o
        && !digital_supply_sel_o)
        else $error("temperature select wrong");
    a_avdd_sel: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL12]
        (mon == assc_pkg::MON_AVDD) |=> analog_supply_sel_o && !temp_sel_o)
        else $error("analog supply select wrong");
    a_dvdd_gain: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL12] [RL13]
        (mon == assc_pkg::MON_DVDD) |=> digital_supply_sel_o && eff_gain_o == 3'd0
        && !inputs_connect_o)
        else $error("digital supply path wrong");
    a_amp_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL14]
        1'b1 |=> amp_enable_o == $past(gain_r[6:5]))
        else $error("amplifier enable mismatch");
    a_burnout_off: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL15]
        (mon < assc_pkg::MON_BO_0P2) |=> !burnout_en_o && burnout_level_o == 2'd0)
        else $error("burnout on without request");
    a_burnout_low: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL15] [RL16]
        (mon == assc_pkg::MON_BO_0P2) |=> burnout_en_o && burnout_level_o == 2'd1)
        else $error("lowest burnout level wrong");
    a_off_plain: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL24]
        (mon == assc_pkg::MON_OFF) |=> !temp_sel_o && !analog_supply_sel_o
        && !digital_supply_sel_o)
        else $error("monitor off still selects");

    // Status flags keep their meaning between resets.
    a_por_keep: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL20]
        !por_r |=> !por_r)
        else $error("power-on flag set by write");
    a_rdy_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL21]
        rdy_r |=> rdy_r)
        else $error("ready flag dropped");
    a_status_read: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL18]
        (reg_addr_i == assc_pkg::ADDR_STATUS) |=> reg_rdata_o
        == {$past(por_r), $past(rdy_r), 5'd0, $past(reflow_r)})
        else $error("status byte read wrong");
    a_reflow_upd: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL22] [RL23]
        conv_done_i |=> reflow_r == $past(ref_fault_r | ref_low_i) && !data_ready_n_o)
        else $error("reference flag not updated");
    a_reflow_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL23]
        !conv_done_i |=> $stable(reflow_r))
        else $error("reference flag moved between conversions");

    c_temp: cover property (@(posedge ref_clk_i) temp_sel_o);
    c_por_clr: cover property (@(posedge ref_clk_i) $fell(por_r));
    c_cmd_start: cover property (@(posedge ref_clk_i) start_cmd_i && conv_start_o);
    c_supply: cover property (@(posedge ref_clk_i) analog_supply_sel_o || digital_supply_sel_o);
    c_ref_low: cover property (@(posedge ref_clk_i) reflow_r && !data_ready_n_o);
endmodule

// file: rtl/assc_pkg.sv
// Purpose: Shared constants for the converter sensor-support control block.
// Assumes: Eight-bit registers reached through a simple write/read port.
// Notes: Offsets are register addresses of the serial register map.
package assc_pkg;
    // Register offsets.
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_GAIN = 8'h03;
    localparam logic [7:0] ADDR_RATE = 8'h04;
    localparam logic [7:0] ADDR_EXC_MAG = 8'h06;
    localparam logic [7:0] ADDR_EXC_ROUTE = 8'h07;
    localparam logic [7:0] ADDR_BIAS_SEL = 8'h08;
    localparam logic [7:0] ADDR_SYS_CTRL = 8'h09;
    // Status byte bit positions.
    localparam int POS_POR = 7;
    localparam int POS_RDY = 6;
    localparam int POS_REFLOW = 0;
    // Reset values.
    localparam logic [7:0] RST_GAIN = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h14;
    localparam logic [7:0] RST_EXC_MAG = 8'h00;
    localparam logic [7:0] RST_EXC_ROUTE = 8'hFF;
    localparam logic [7:0] RST_BIAS_SEL = 8'h00;
    localparam logic [7:0] RST_SYS_CTRL = 8'h10;
    // Data-rate code at and below which line rejection is available (60 SPS).
    localparam logic [3:0] RATE_LINE_REJ_MAX = 4'h6;
    // Start command is taken on this serial clock falling edge.
    localparam logic [2:0] START_SCLK_EDGE = 3'd7;
    // Startup delay in clock cycles before the ready flag is raised.
    localparam int STARTUP_CYCLES = 16;
    // Monitor selector codes.
    localparam logic [2:0] MON_OFF = 3'b000;
    localparam logic [2:0] MON_MID = 3'b001;
    localparam logic [2:0] MON_TEMP = 3'b010;
    localparam logic [2:0] MON_AVDD = 3'b011;
    localparam logic [2:0] MON_DVDD = 3'b100;
    localparam logic [2:0] MON_BO_0P2 = 3'b101;
    localparam logic [2:0] MON_BO_1 = 3'b110;
    localparam logic [2:0] MON_BO_10 = 3'b111;
endpackage

// file: verification/assc_host.sv
// Purpose: Host model driving the register port and start commands.
// Assumes: The block samples its inputs on the rising clock edge.
// Notes: Everything changes on the falling edge; released data is inverted.
`timescale 1ns/1ps
module assc_host #(
    parameter int SETTLE = 4
) (
    // Clock.
    input wire logic ref_clk_i,
    // Register port and start command.
    output logic reg_wr_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic start_cmd_o,
    output logic sclk_fall_o
);
    // Idle levels from time zero.
    initial
    begin
        reg_wr_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        start_cmd_o = 1'b0;
        sclk_fall_o = 1'b0;
    end
    // One write over a single edge, then time for the decoded outputs.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(negedge ref_clk_i);
        reg_wr_o = 1'b0;
        reg_wdata_o = ~d;
        repeat (2) @(negedge ref_clk_i);
    endtask
    // Presents a read address; data is settled at the return.
    task automatic rd(input logic [7:0] a);
        @(negedge ref_clk_i);
        reg_addr_o = a;
        @(negedge ref_clk_i);
    endtask
    // A full start byte of eight serial clock falls, after bias settling.
    task automatic start_cmd();
        repeat (SETTLE) @(negedge ref_clk_i);
        start_cmd_o = 1'b1;
        repeat (8)
        begin
            @(negedge ref_clk_i);
            sclk_fall_o = 1'b1;
            @(negedge ref_clk_i);
            sclk_fall_o = 1'b0;
        end
        @(negedge ref_clk_i);
        start_cmd_o = 1'b0;
    endtask
endmodule

// file: verification/testbench.sv
// Purpose: Self-checking bench for the sensor-support control block.
// Assumes: Inputs change on the falling edge; the seed is fixed.
// Notes: Startup count shortened to 4 cycles.
`timescale 1ns/1ps
module testbench;
    logic ref_clk_i = 1'b0;
    logic rst_i;
    logic start_pin_i;
    logic conv_done_i;
    logic ref_low_i;
    logic reg_wr, start_cmd, sclk_fall, conv_start, line_rej, conn, temp, an, dg, ben, data_ready_pin_n;
    logic [7:0] addr, wdata, rdata, d, g, at_seven, pulses;
    logic [3:0] mag, r1, r2;
    logic [6:0] bias;
    logic [2:0] gain, s;
    logic [1:0] amp, lvl;
    int err_total = 0;
    int n_compared = 0;
    int starts = 0;
    int b;
    // Free-running clock, 50 ns period.
    always #25 ref_clk_i = ~ref_clk_i;
    // Counts start pulses and the serial clock falls of the current command.
    always @(posedge ref_clk_i)
    begin
        if (conv_start)
        begin
            starts <= starts + 1;
            at_seven <= pulses;
        end
        pulses <= !start_cmd ? 8'h00 : pulses + 8'(sclk_fall);
    end
    assc_host host (.ref_clk_i(ref_clk_i), .reg_wr_o(reg_wr), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .start_cmd_o(start_cmd), .sclk_fall_o(sclk_fall));
    assc_ctrl #(.STARTUP(4)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .start_pin_i(start_pin_i),
        .start_cmd_i(start_cmd), .sclk_fall_i(sclk_fall), .conv_done_i(conv_done_i),
        .ref_low_i(ref_low_i), .conv_start_o(conv_start), .line_rej_o(line_rej),
        .current_magnitude_field_o(mag), .first_current_route_o(r1),
        .second_current_route_o(r2), .bias_pin_select_o(bias), .inputs_connect_o(conn),
        .temp_sel_o(temp), .analog_supply_sel_o(an), .digital_supply_sel_o(dg),
        .eff_gain_o(gain), .amp_enable_o(amp), .burnout_level_o(lvl),
        .burnout_en_o(ben), .data_ready_n_o(data_ready_pin_n));
    // Compares one value and counts it.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Waits, bounded, for a start pulse beyond the count given.
    task automatic wait_start(input int base);
        int k;
        k = 0;
        while (starts == base && k < 40)
        begin
            @(negedge ref_clk_i);
            k++;
        end
        if (starts == base)
        begin
            err_total++;
            print_verdict();
        end
    endtask
    // Expected selector decode: connect, temp, supplies, burnout enable, level.
    function automatic logic [7:0] mon_exp(input logic [2:0] sel);
        logic bo;
        bo = sel >= 3'h5;
        return {1'b0, !(sel inside {3'h2, 3'h3, 3'h4}), sel == 3'h2, sel == 3'h3,
            sel == 3'h4, bo, bo ? sel[1:0] : 2'h0};
    endfunction
    // Cuts a hang short.
    initial
    begin
        #2_000_000;
        err_total++;
        print_verdict();
    end
    // Main sequence.
    initial
    begin
        rst_i = 1'b1;
        start_pin_i = 1'b0;
        conv_done_i = 1'b0;
        ref_low_i = 1'b0;
        void'($urandom(32'h6c89));
        repeat (8) @(negedge ref_clk_i);
        rst_i = 1'b0;
        host.rd(8'h01);
        chk(rdata & 8'hC1, 8'h80);
        repeat (8) @(negedge ref_clk_i);
        foreach (d[i])
        begin
            g = (i == 6) ? 8'h00 : 8'hFF;
            host.wr(8'h01, g);
            host.rd(8'h01);
            chk(rdata & 8'hC0, (i == 7) ? 8'hC0 : 8'h40);
        end
        host.wr(8'h02, 8'hA5);
        host.rd(8'h02);
        chk(rdata, 8'h00);
        $display("status test done");
        // The reference is switched on before the sources are set; its register is not ours.
        host.wr(8'h05, 8'h01);
        host.rd(8'h05);
        chk(rdata, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            d = (i == 0) ? 8'h33 : 8'($urandom);
            host.wr(8'h06, d);
            host.wr(8'h07, d);
            host.wr(8'h08, d);
            host.rd(8'h07);
            chk(rdata, d);
            chk({4'h0, mag}, {4'h0, d[3:0]});
            chk({r2, r1}, d);
            chk({1'b0, bias}, {1'b0, d[6:0]});
        end
        for (int c = 0; c < 16; c++)
        begin
            host.wr(8'h04, {4'h1, 4'(c)});
            chk({7'h00, line_rej}, {7'h00, c <= 6});
        end
        $display("register test done");
        // The host keeps the gain at 4 or below while the temperature sensor is read.
        for (int i = 0; i < 16; i++)
        begin
            s = 3'(i);
            g = (s == 3'h2) ? 8'($urandom % 3) : 8'($urandom);
            host.wr(8'h03, g);
            host.wr(8'h09, {s, 5'($urandom)});
            chk({1'b0, conn, temp, an, dg, ben, lvl}, mon_exp(s));
            chk({3'h0, amp, gain}, {3'h0, g[6:5], (s inside {3'h3, 3'h4}) ? 3'h0 : g[2:0]});
        end
        // Burnout currents are switched off again before precision work.
        host.wr(8'h09, 8'h00);
        chk({7'h00, ben}, 8'h00);
        $display("monitor test done");
        b = starts;
        start_pin_i = 1'b1;
        wait_start(b);
        chk(8'(starts - b), 8'h01);
        start_pin_i = 1'b0;
        b = starts;
        host.start_cmd();
        chk(8'(starts - b), 8'h01);
        chk(at_seven, 8'h07);
        chk({7'h00, data_ready_pin_n}, 8'h01);
        $display("start test done");
        for (int v = 1; v >= 0; v--)
        begin
            @(negedge ref_clk_i);
            ref_low_i = 1'(v);
            @(negedge ref_clk_i);
            ref_low_i = 1'b0;
            conv_done_i = 1'b1;
            @(negedge ref_clk_i);
            conv_done_i = 1'b0;
            repeat (2) @(negedge ref_clk_i);
            host.rd(8'h01);
            chk(rdata & 8'h01, 8'(v));
            chk({7'h00, data_ready_pin_n}, 8'h00);
        end
        b = starts;
        start_pin_i = 1'b1;
        wait_start(b);
        start_pin_i = 1'b0;
        chk({7'h00, data_ready_pin_n}, 8'h01);
        // A second reset in mid-run raises the power-on flag again.
        rst_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        rst_i = 1'b0;
        host.rd(8'h01);
        chk(rdata & 8'hC1, 8'h80);
        $display("reference flag test done");
        print_verdict();
    end
endmodule
